//--- src/eeprom_access_consts.vh
// Purpose: Shared constants for the byte-wide nonvolatile access controller
// Assumes: APB with 32-bit data, pclk at 10 MHz
// Notes:   Offsets are byte addresses of aligned 32-bit words
`ifndef EEPROM_ACCESS_CONSTS_VH
`define EEPROM_ACCESS_CONSTS_VH

// Bus geometry
`define APB_AW            12
`define APB_DW            32

// Register byte offsets
`define OFF_CTRL          12'h000
`define OFF_ADDR          12'h004
`define OFF_DATA          12'h008
`define OFF_STAT          12'h00C

// Control register bit positions
`define CTL_RD_BIT        0
`define CTL_WS_BIT        1
`define CTL_ARM_BIT       2
`define CTL_IRQ_BIT       3

// Status register bit positions
`define STAT_SPM_BIT      0
`define STAT_BUSY_BIT     1
`define STAT_HALT_BIT     2

// Array geometry: 512 bytes, linear 9-bit address
`define NV_AW             9
`define NV_DW             8
`define NV_DEPTH          512

// Reset values
`define CTRL_RST          1'b0
`define ADDR_RST          9'h000
`define DATA_RST          8'h00
`define WORD_ZERO         32'h0000_0000

// Arming window and CPU halt lengths in pclk cycles
`define ARM_WINDOW_CYC    3'h4
`define ARM_LAST_CYC      3'h1
`define ARM_CNT_ZERO      3'h0
`define WRITE_HALT_CYC    3'h2
`define READ_HALT_CYC     3'h4
`define HALT_ZERO         3'h0
`define HALT_ONE          3'h1

// Write timing on the calibrated 1 MHz oscillator
`define PCLK_FREQ_HZ      10000000
`define OSC_FREQ_HZ       1000000
`define WRITE_TIME_OSC    14'h2100   // 8448 oscillator ticks
`define OSC_DIV_W         4
`define OSC_DIV_LAST      4'h9       // Ten pclk cycles per oscillator tick
`define OSC_DIV_ZERO      4'h0
`define OSC_DIV_ONE       4'h1
`define WTICK_W           14
`define WTICK_ZERO        14'h0000
`define WTICK_ONE         14'h0001

`endif

//--- src/nv_byte_array.v
// Purpose: 512 x 8 nonvolatile byte array model with registered read
// Assumes: One clock, write and read never in the same cycle
// Notes:   Read data appears one cycle after rd_en
`timescale 1ns/1ns
`include "eeprom_access_consts.vh"

module nv_byte_array (
   input  wire                  pclk,
   input  wire                  presetn,
   input  wire                  wr_en,
   input  wire [`NV_AW-1:0]     wr_addr,
   input  wire [`NV_DW-1:0]     wr_data,
   input  wire                  rd_en,
   input  wire [`NV_AW-1:0]     rd_addr,
   output reg  [`NV_DW-1:0]     rd_data
);

   reg [`NV_DW-1:0] cells [0:`NV_DEPTH-1];

   // Cell programming
   always @(posedge pclk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= `DATA_RST;
      end else if (rd_en) begin
         rd_data <= cells[rd_addr];
      end
   end

endmodule // nv_byte_array

//--- src/eeprom_access_control.v
// Purpose: APB-controlled access logic for a 512-byte nonvolatile byte array
// Assumes: pclk 10 MHz; self_program_busy synchronous to pclk
// Notes:   Write time counted on a 1 MHz enable derived from pclk
//
// Notes on behaviour
// R1: Strobe while armed starts a byte program
// R2: Strobe without arming does nothing
// R3: Software arms, then strobes within four cycles
// R4: Software waits for strobe and flash idle
// R5: Address and data load in any order
// R6: No programming while flash self-programming busy
// R7: Expired arming window abandons the write
// R8: Software keeps interrupts off during sequence
// R9: Hardware clears write strobe at completion
// R10: Write strobe halts CPU two cycles
// R11: Read strobe fetches addressed byte into data
// R12: Read strobe halts CPU four cycles
// R13: During write, no read, no address change
// R14: Write lasts 8448 cycles of 1 MHz
// R15: Power-down sleep lets active write finish
// R16: Software checks write done before power-down
// R17: Arming bit self-clears after four cycles
// R18: Ready request high while strobe clear, enabled
// R19: Linear 9-bit byte address
// R20: Writing zero to busy strobe ignored
`timescale 1ns/1ns
`include "eeprom_access_consts.vh"

module eeprom_access_control #(
   parameter [`WTICK_W-1:0] WRITE_OSC_TICKS = `WRITE_TIME_OSC
) (
   input  wire                  pclk,
   input  wire                  presetn,
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [`APB_AW-1:0]    paddr,
   input  wire [`APB_DW-1:0]    pwdata,
   output reg  [`APB_DW-1:0]    prdata,
   output reg                   pready,
   output reg                   pslverr,
   input  wire                  self_program_busy,
   input  wire                  sleep_powerdown,
   output reg                   ready_irq,
   output reg                   cpu_halt,
   output reg                   osc_running,
   output reg                   powerdown_held
);

   // Address match, used by every decode below
   function reg_hit;
      input [`APB_AW-1:0] addr;
      input [`APB_AW-1:0] offset;
      begin
         reg_hit = (addr == offset);
      end
   endfunction

   // Software-visible state
   reg                  read_strobe_bit_q;
   reg                  write_strobe_bit_q;
   reg                  write_arm_bit_q;
   reg                  ready_irq_enable_q;
   reg [`NV_AW-1:0]     byte_address_reg_q;
   reg [`NV_DW-1:0]     byte_data_reg_q;

   // Internal sequencing state
   reg [2:0]            arm_cnt_q;
   reg [2:0]            halt_cnt_q;
   reg [2:0]            halt_cnt_d;
   reg [`OSC_DIV_W-1:0] osc_div_q;
   reg [`WTICK_W-1:0]   wtick_q;
   reg [`NV_AW-1:0]     prog_addr_q;
   reg [`NV_DW-1:0]     prog_data_q;
   reg                  rd_pend_q;

   wire [`NV_DW-1:0]    array_rd_data;

   // Bus strobes: a transfer completes at the edge where pready is high
   wire acc_done  = psel & penable & pready;
   wire wr_done   = acc_done & pwrite;
   wire wr_ctrl   = wr_done & reg_hit(paddr, `OFF_CTRL);
   wire wr_addr   = wr_done & reg_hit(paddr, `OFF_ADDR);
   wire wr_data   = wr_done & reg_hit(paddr, `OFF_DATA);
   wire mapped    = reg_hit(paddr, `OFF_CTRL) | reg_hit(paddr, `OFF_ADDR) |
                    reg_hit(paddr, `OFF_DATA) | reg_hit(paddr, `OFF_STAT);

   wire set_arm   = pwdata[`CTL_ARM_BIT];
   wire set_ws    = pwdata[`CTL_WS_BIT];
   wire set_rd    = pwdata[`CTL_RD_BIT];

   // Write start: strobe while armed, idle and flash idle
   wire write_go  = wr_ctrl & set_ws & write_arm_bit_q &        // R1 R2 R7
                    ~write_strobe_bit_q & ~self_program_busy;   // R6
   // Read start: never while programming
   wire read_go   = wr_ctrl & set_rd & ~write_strobe_bit_q;     // R13

   // One-microsecond enable from the pclk divider
   wire osc_tick  = write_strobe_bit_q & (osc_div_q == `OSC_DIV_LAST);
   wire write_end = osc_tick & (wtick_q == WRITE_OSC_TICKS - `WTICK_ONE); // R14

   // Answer cycle: access phase open and no CPU halt left to run
   wire answer    = psel & penable & ~pready & (halt_cnt_d == `HALT_ZERO); // R10 R12

   // APB answer: one wait state, stretched while the CPU is halted
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= answer;                                          // R10 R12
      end
   end

   // Read data and error flag captured with the answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= `WORD_ZERO;
         pslverr <= 1'b0;
      end else if (answer) begin
         pslverr <= ~mapped;                                        // Only with pready
         prdata  <= `WORD_ZERO;
         if (!pwrite) begin
            if (reg_hit(paddr, `OFF_CTRL)) begin
               prdata[`CTL_RD_BIT]  <= read_strobe_bit_q;
               prdata[`CTL_WS_BIT]  <= write_strobe_bit_q;
               prdata[`CTL_ARM_BIT] <= write_arm_bit_q;
               prdata[`CTL_IRQ_BIT] <= ready_irq_enable_q;
            end else if (reg_hit(paddr, `OFF_ADDR)) begin
               prdata[`NV_AW-1:0] <= byte_address_reg_q;            // R19
            end else if (reg_hit(paddr, `OFF_DATA)) begin
               prdata[`NV_DW-1:0] <= byte_data_reg_q;
            end else if (reg_hit(paddr, `OFF_STAT)) begin
               prdata[`STAT_SPM_BIT]  <= self_program_busy;
               prdata[`STAT_BUSY_BIT] <= write_strobe_bit_q;
               prdata[`STAT_HALT_BIT] <= cpu_halt;
            end
         end
      end else begin
         pslverr <= 1'b0;
      end
   end

   // Arming bit with its four-cycle lifetime
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_arm_bit_q <= `CTRL_RST;
         arm_cnt_q       <= `ARM_CNT_ZERO;
      end else if (wr_ctrl & set_arm & ~set_ws) begin
         write_arm_bit_q <= 1'b1;                                   // R3
         arm_cnt_q       <= `ARM_WINDOW_CYC;                        // R17
      end else if (arm_cnt_q != `ARM_CNT_ZERO) begin
         arm_cnt_q <= arm_cnt_q - `ARM_LAST_CYC;
         if (arm_cnt_q == `ARM_LAST_CYC) begin
            write_arm_bit_q <= 1'b0;                                // R17 R7
         end
      end
   end

   // Ready interrupt enable bit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_irq_enable_q <= `CTRL_RST;
      end else if (wr_ctrl) begin
         ready_irq_enable_q <= pwdata[`CTL_IRQ_BIT];
      end
   end

   // Write strobe: set on a valid start, cleared only by completion
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         write_strobe_bit_q <= `CTRL_RST;
      end else if (write_go) begin
         write_strobe_bit_q <= 1'b1;                                // R1
      end else if (write_end) begin
         write_strobe_bit_q <= 1'b0;                                // R9 R20
      end
   end

   // Latch target byte and value at the start of programming
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_addr_q <= `ADDR_RST;
         prog_data_q <= `DATA_RST;
      end else if (write_go) begin
         prog_addr_q <= byte_address_reg_q;                         // R5
         prog_data_q <= byte_data_reg_q;
      end
   end

   // Calibrated oscillator model: runs only while programming
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_div_q <= `OSC_DIV_ZERO;
      end else if (!write_strobe_bit_q || osc_tick) begin
         osc_div_q <= `OSC_DIV_ZERO;
      end else begin
         osc_div_q <= osc_div_q + `OSC_DIV_ONE;
      end
   end

   // Programming time in oscillator ticks, unaffected by sleep
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wtick_q <= `WTICK_ZERO;
      end else if (write_go || write_end) begin
         wtick_q <= `WTICK_ZERO;
      end else if (osc_tick) begin
         wtick_q <= wtick_q + `WTICK_ONE;                           // R14 R15
      end
   end

   // Address register, frozen while programming
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_address_reg_q <= `ADDR_RST;
      end else if (wr_addr & ~write_strobe_bit_q) begin
         byte_address_reg_q <= pwdata[`NV_AW-1:0];                  // R13 R19
      end
   end

   // Data register: software load or fetched byte
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         byte_data_reg_q <= `DATA_RST;
      end else if (rd_pend_q) begin
         byte_data_reg_q <= array_rd_data;                          // R11
      end else if (wr_data) begin
         byte_data_reg_q <= pwdata[`NV_DW-1:0];                     // R5
      end
   end

   // Read in flight: data lands the cycle after the array read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_pend_q <= 1'b0;
      end else begin
         rd_pend_q <= read_go;                                      // R11
      end
   end

   // Read strobe stays visible for the read halt
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_strobe_bit_q <= `CTRL_RST;
      end else if (read_go) begin
         read_strobe_bit_q <= 1'b1;
      end else if (halt_cnt_q == `HALT_ZERO) begin
         read_strobe_bit_q <= 1'b0;
      end
   end

   // Next halt count
   always @* begin
      halt_cnt_d = halt_cnt_q;
      if (write_go) begin
         halt_cnt_d = `WRITE_HALT_CYC;                              // R10
      end else if (wr_ctrl & set_rd) begin
         halt_cnt_d = `READ_HALT_CYC;                               // R12
      end else if (halt_cnt_q != `HALT_ZERO) begin
         halt_cnt_d = halt_cnt_q - `HALT_ONE;
      end
   end

   // Halt counter and its flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_cnt_q <= `HALT_ZERO;
         cpu_halt   <= 1'b0;
      end else begin
         halt_cnt_q <= halt_cnt_d;
         cpu_halt   <= (halt_cnt_d != `HALT_ZERO);                  // R10 R12
      end
   end

   // Ready request while idle and enabled
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_irq <= 1'b0;
      end else begin
         ready_irq <= ready_irq_enable_q & ~(write_strobe_bit_q & ~write_end); // R18
      end
   end

   // Oscillator kept alive by an active write, even in power-down
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_running    <= 1'b0;
         powerdown_held <= 1'b0;
      end else begin
         osc_running    <= write_go | (write_strobe_bit_q & ~write_end);  // R15
         powerdown_held <= sleep_powerdown &
                           (write_go | (write_strobe_bit_q & ~write_end)); // R15
      end
   end

   // Byte array
   nv_byte_array u_array (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (write_end),
      .wr_addr (prog_addr_q),
      .wr_data (prog_data_q),
      .rd_en   (read_go),
      .rd_addr (byte_address_reg_q),
      .rd_data (array_rd_data)
   );

endmodule // eeprom_access_control

//--- tb/eeprom_access_monitor.sv
// Purpose: Port-level checks on the nonvolatile access controller
// Assumes: Single pclk domain, async active-low reset
// Notes:   Write length allows slack, though the 1 MHz tick divider restarts at each write
`timescale 1ns/1ns
`include "eeprom_access_consts.vh"
module eeprom_access_monitor #(
   parameter [`WTICK_W-1:0] WRITE_OSC_TICKS = `WRITE_TIME_OSC
) (
   input wire               pclk,
   input wire               presetn,
   input wire               psel,
   input wire               penable,
   input wire               pwrite,
   input wire [`APB_AW-1:0] paddr,
   input wire [`APB_DW-1:0] pwdata,
   input wire [`APB_DW-1:0] prdata,
   input wire               pready,
   input wire               pslverr,
   input wire               sleep_powerdown,
   input wire               ready_irq,
   input wire               cpu_halt,
   input wire               osc_running,
   input wire               powerdown_held
);
   wire commit = psel && penable && pready;
   wire rd_go  = commit && pwrite && (paddr == `OFF_CTRL) && pwdata[`CTL_RD_BIT];
   int  halt_len;
   int  run_len;
   // Lengths of halt and program intervals
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_len <= 0;
         run_len  <= 0;
      end else begin
         halt_len <= cpu_halt ? halt_len + 1 : 0;
         run_len  <= osc_running ? run_len + 1 : 0;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready too long");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_unmapped_err: assert property (commit && paddr > `OFF_STAT |-> pslverr)
      else $error("unmapped access not refused");
   a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == `WORD_ZERO)
      else $error("refused read not zero");
   a_halt_blocks_ready: assert property (cpu_halt && $past(cpu_halt) |-> !pready)
      else $error("access ended during halt");
   a_halt_length: assert property ($fell(cpu_halt) |-> halt_len == 2 || halt_len == 4)
      else $error("halt length wrong");
   a_read_halts: assert property (rd_go |-> ##[1:2] cpu_halt)
      else $error("read strobe did not halt");
   a_write_length: assert property ($fell(osc_running) |->
      run_len >= 10 * (WRITE_OSC_TICKS - 1) && run_len <= 10 * WRITE_OSC_TICKS + 2)
      else $error("program time wrong");
   a_busy_no_irq: assert property (osc_running && $past(osc_running) |-> !ready_irq)
      else $error("ready request during write");
   a_sleep_held: assert property ($past(sleep_powerdown) && osc_running && $past(osc_running)
      |-> powerdown_held)
      else $error("power-down not held off");
endmodule // eeprom_access_monitor

//--- tb/cpu_apb_master.sv
// Purpose: CPU-side model issuing register accesses over APB
// Assumes: Tasks are entered right after a rising pclk edge
// Notes:   psel stays up between back-to-back calls until idle runs
`timescale 1ns/1ns
`include "eeprom_access_consts.vh"
module cpu_apb_master (
   input  wire               pclk,
   output reg                psel,
   output reg                penable,
   output reg                pwrite,
   output reg  [`APB_AW-1:0] paddr,
   output reg  [`APB_DW-1:0] pwdata,
   input  wire [`APB_DW-1:0] prdata,
   input  wire               pready,
   input  wire               pslverr
);
   int tmo = 0;
   // Bus idle at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
   end
   // One whole transfer, never interrupted by other traffic
   task xfer(input w, input [`APB_AW-1:0] a, input [`APB_DW-1:0] d,
             output [`APB_DW-1:0] q, output e);
      int i;
      begin
         psel   <= 1'b1;
         pwrite <= w;
         paddr  <= a;
         pwdata <= d;
         @(posedge pclk) penable <= 1'b1;
         i = 0;
         do begin
            @(posedge pclk);
            i++;
         end while (!pready && i < 64);
         q = prdata;
         e = pslverr;
         penable <= 1'b0;
         if (i >= 64) tmo++;
      end
   endtask
   // Release the bus for n cycles
   task idle(input int n);
      psel <= 1'b0;
      repeat (n) @(posedge pclk);
   endtask
endmodule // cpu_apb_master

//--- tb/eeprom_access_control_bench.sv
// Purpose: Directed register-level tests of the access controller
// Assumes: Program time shortened to 8 oscillator ticks
// Notes:   Expected values come from the register map and rules only
`timescale 1ns/1ns
`include "eeprom_access_consts.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin bad_count++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module eeprom_access_control_bench;
   reg               pclk = 1'b0;
   reg               presetn = 1'b0;
   reg               self_program_busy = 1'b0;
   reg               sleep_powerdown = 1'b0;
   wire              psel, penable, pwrite, pready, pslverr;
   wire              ready_irq, cpu_halt, osc_running, powerdown_held;
   wire [`APB_AW-1:0] paddr;
   wire [`APB_DW-1:0] pwdata, prdata;
   reg  [`APB_DW-1:0] q;
   reg               e;
   int               bad_count = 0;
   int               n_tests = 0;
   int               i;
   // Clock at 10 MHz
   always #50 pclk = ~pclk;
   cpu_apb_master cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   eeprom_access_control #(.WRITE_OSC_TICKS(14'h0008)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .self_program_busy(self_program_busy), .sleep_powerdown(sleep_powerdown),
      .ready_irq(ready_irq), .cpu_halt(cpu_halt), .osc_running(osc_running),
      .powerdown_held(powerdown_held));
   task wr(input [`APB_AW-1:0] a, input [`APB_DW-1:0] d);
      cpu.xfer(1'b1, a, d, q, e);
      if (cpu.tmo != 0) stop_test;
   endtask
   task rd(input [`APB_AW-1:0] a);
      cpu.xfer(1'b0, a, 32'h0000_0000, q, e);
      if (cpu.tmo != 0) stop_test;
   endtask
   // Poll the strobe bit until the program cycle ends
   task wait_done;
      i = 0;
      rd(`OFF_CTRL);
      while (q[`CTL_WS_BIT] !== 1'b0 && i < 400) begin
         rd(`OFF_CTRL);
         i++;
      end
      if (i >= 400) begin
         bad_count++;
         stop_test;
      end
   endtask
   task stop_test;
      bad_count += cpu.tmo;
      $display("checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      stop_test;
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int k = 0; k < 4; k++) begin
         rd(12'(4 * k));
         `CHK(q, 32'h0000_0000)
      end
      rd(12'h010);
      `CHK({e, q}, 33'h0_0000_0000 | 33'h1_0000_0000)
      $display("test reset and map done");
      wr(`OFF_DATA, 32'h0000_00A5);
      wr(`OFF_ADDR, 32'h0000_01FF);
      wr(`OFF_CTRL, 32'h0000_000C);
      wr(`OFF_CTRL, 32'h0000_000A);
      rd(`OFF_STAT);
      `CHK(q[`STAT_BUSY_BIT], 1'b1)
      wr(`OFF_CTRL, 32'h0000_0008);
      rd(`OFF_CTRL);
      `CHK(q[`CTL_WS_BIT], 1'b1)
      wait_done;
      cpu.idle(2);
      `CHK(ready_irq, 1'b1)
      wr(`OFF_CTRL, 32'h0000_0001);
      rd(`OFF_DATA);
      `CHK(q, 32'h0000_00A5)
      $display("test armed write done");
      wr(`OFF_CTRL, 32'h0000_0002);
      rd(`OFF_STAT);
      `CHK(q[`STAT_BUSY_BIT], 1'b0)
      wr(`OFF_CTRL, 32'h0000_0004);
      cpu.idle(6);
      rd(`OFF_CTRL);
      `CHK(q[`CTL_ARM_BIT], 1'b0)
      wr(`OFF_CTRL, 32'h0000_0002);
      rd(`OFF_STAT);
      `CHK(q[`STAT_BUSY_BIT], 1'b0)
      self_program_busy <= 1'b1;
      wr(`OFF_CTRL, 32'h0000_0004);
      wr(`OFF_CTRL, 32'h0000_0002);
      rd(`OFF_STAT);
      `CHK(q[1:0], 2'h1)
      self_program_busy <= 1'b0;
      $display("test refused writes done");
      wr(`OFF_ADDR, 32'h0000_0000);
      wr(`OFF_DATA, 32'h0000_003C);
      wr(`OFF_CTRL, 32'h0000_0004);
      wr(`OFF_CTRL, 32'h0000_0002);
      sleep_powerdown <= 1'b1;
      wr(`OFF_ADDR, 32'h0000_0055);
      rd(`OFF_ADDR);
      `CHK(q, 32'h0000_0000)
      `CHK(powerdown_held, 1'b1)
      wait_done;
      `CHK(powerdown_held, 1'b0)
      sleep_powerdown <= 1'b0;
      wr(`OFF_CTRL, 32'h0000_0001);
      rd(`OFF_DATA);
      `CHK(q, 32'h0000_003C)
      wr(`OFF_ADDR, 32'h0000_01FF);
      wr(`OFF_CTRL, 32'h0000_0001);
      rd(`OFF_DATA);
      `CHK(q, 32'h0000_00A5)
      $display("test busy and sleep done");
      cpu.idle(2);
      stop_test;
   end
endmodule // eeprom_access_control_bench
bind eeprom_access_control eeprom_access_monitor #(.WRITE_OSC_TICKS(WRITE_OSC_TICKS)) mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sleep_powerdown(sleep_powerdown), .ready_irq(ready_irq), .cpu_halt(cpu_halt),
   .osc_running(osc_running), .powerdown_held(powerdown_held));
